// ===== hdl/dmbc_top.sv
`timescale 1ns/100ps
`include "dmbc_regs.svh"
module dmbc_top #(
  parameter int REFRESH_PERIOD_CYC = `DMBC_REFRESH_PERIOD_CYC,
  parameter int PAR_DELAY_CYC      = `DMBC_PAR_DELAY_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [17:0] bus_dal_in,
  input  wire logic        bus_sync,
  input  wire logic        bus_din,
  input  wire logic        bus_dout,
  input  wire logic        bus_wtbt,
  input  wire logic        bus_bank7,
  input  wire logic        outside_refresh_seen,
  output logic             bus_reply,
  output logic [17:0]      bus_dal_out,
  output logic             bus_dal_oe_n,
  output logic [6:0]       muxed_chip_address,
  output logic             row_strobe_low_array_n,
  output logic             row_strobe_high_array_n,
  output logic             col_strobe_a_n,
  output logic             col_strobe_b_n,
  output logic             byte_write_low_n,
  output logic             byte_write_high_n,
  output logic [15:0]      mem_wdata,
  input  wire logic [15:0] mem_rdata,
  output logic [1:0]       par_wdata,
  input  wire logic [1:0]  par_rdata
);
  logic [8:0]            cfg;
  logic                  fault_sticky;
  logic                  parity_fault_latched;
  logic                  aw_held;
  logic                  w_held;
  logic [3:0]            aw_q;
  logic [31:0]           w_q;
  logic [3:0]            strb_q;
  logic                  do_write;
  logic                  sync_q;
  logic                  read_flag;
  logic                  write_flag;
  logic                  read_done;
  logic                  write_done;
  logic                  hit_q_high;
  logic [6:0]            row_q;
  logic [6:0]            col_q;
  logic                  a0_q;
  logic                  board_hit;
  logic                  high_range;
  logic [6:0]            row_addr;
  logic [6:0]            col_addr;
  logic                  read_request;
  logic                  write_request;
  logic                  refresh_tick;
  logic                  refresh_done;
  logic [6:0]            refresh_row;
  logic                  refresh_pending;
  logic                  cycle_lock;
  logic                  is_write;
  logic                  portion_done;
  logic                  fault_now;
  logic [3:0]            seq_cnt;
  logic [3:0]            reply_cnt;
  logic [15:0]           rd_data_q;
  dmbc_pkg::dmbc_state_t state;
  assign do_write   = aw_held & w_held & ~bvalid;
  assign cycle_lock = (state != dmbc_pkg::DMBC_IDLE);
  assign read_request  = read_flag & ~read_done;
  assign write_request = (write_flag | read_done) & bus_dout & ~write_done;
  assign fault_now = cfg[`DMBC_CFG_PARITY_BIT]
                   & (((^mem_rdata[7:0]) != par_rdata[0]) | ((^mem_rdata[15:8]) != par_rdata[1]));

  dmbc_range_decode u_decode (
    .bus_addr               (bus_dal_in),
    .start_address_switches (cfg[`DMBC_CFG_START_LSB +: 5]),
    .bank7_lower_en         (cfg[`DMBC_CFG_BANK7_BIT]),
    .chips16k               (cfg[`DMBC_CFG_CHIP16K_BIT]),
    .chips32                (cfg[`DMBC_CFG_CHIP32_BIT]),
    .bus_bank7              (bus_bank7),
    .outside_refresh_seen   (outside_refresh_seen),
    .board_hit              (board_hit),
    .high_range             (high_range),
    .row_addr               (row_addr),
    .col_addr               (col_addr)
  );

  dmbc_refresh_timer #(
    .PERIOD_CYC (REFRESH_PERIOD_CYC)
  ) u_refresh (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .chips16k     (cfg[`DMBC_CFG_CHIP16K_BIT]),
    .refresh_done (refresh_done),
    .refresh_tick (refresh_tick),
    .refresh_row  (refresh_row)
  );

  // AXI write address and data, accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      aw_q    <= 4'h0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      aw_q    <= awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      w_q    <= 32'h0000_0000;
      strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      w_q    <= wdata;
      strb_q <= wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= dmbc_pkg::DMBC_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= (aw_q == `DMBC_CFG_OFFSET || aw_q == `DMBC_STATUS_OFFSET)
              ? dmbc_pkg::DMBC_RESP_OKAY : dmbc_pkg::DMBC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= `DMBC_CFG_RESET;
    end else if (do_write && aw_q == `DMBC_CFG_OFFSET) begin
      if (strb_q[0]) begin
        cfg[7:0] <= w_q[7:0];
      end
      if (strb_q[1]) begin
        cfg[8] <= w_q[8];
      end
    end
  end

  // Sticky fault: a new fault wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_sticky <= 1'b0;
    end else if (portion_done && !is_write && parity_fault_latched) begin
      fault_sticky <= 1'b1;
    end else if (do_write && aw_q == `DMBC_STATUS_OFFSET && strb_q[0]
                 && w_q[`DMBC_ST_STICKY_BIT]) begin
      fault_sticky <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= dmbc_pkg::DMBC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= dmbc_pkg::DMBC_RESP_OKAY;
      rdata   <= 32'h0000_0000;
      if (araddr == `DMBC_CFG_OFFSET) begin
        rdata[8:0] <= cfg;
      end else if (araddr == `DMBC_STATUS_OFFSET) begin
        rdata[`DMBC_ST_FAULT_BIT]   <= parity_fault_latched;
        rdata[`DMBC_ST_STICKY_BIT]  <= fault_sticky;
        rdata[`DMBC_ST_LOCK_BIT]    <= cycle_lock;
        rdata[`DMBC_ST_REFPEND_BIT] <= refresh_pending;
        rdata[`DMBC_ST_ROW_LSB +: 7] <= refresh_row;
      end else begin
        rresp <= dmbc_pkg::DMBC_RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Address phase capture on the leading edge of sync
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q     <= 1'b0;
      read_flag  <= 1'b0;
      write_flag <= 1'b0;
      hit_q_high <= 1'b0;
      row_q      <= 7'h00;
      col_q      <= 7'h00;
      a0_q       <= 1'b0;
    end else begin
      sync_q <= bus_sync;
      if (!bus_sync) begin
        read_flag  <= 1'b0;
        write_flag <= 1'b0;
      end else if (!sync_q && board_hit) begin
        read_flag  <= ~bus_wtbt;
        write_flag <= bus_wtbt;
        hit_q_high <= high_range;
        row_q      <= row_addr;
        col_q      <= col_addr;
        a0_q       <= bus_dal_in[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      read_done  <= 1'b0;
      write_done <= 1'b0;
    end else if (!bus_sync) begin
      read_done  <= 1'b0;
      write_done <= 1'b0;
    end else if (portion_done) begin
      read_done  <= read_done | ~is_write;
      write_done <= write_done | is_write;
    end
  end

  // Refresh request waits here; a new tick wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_pending <= 1'b0;
    end else if (refresh_tick) begin
      refresh_pending <= 1'b1;
    end else if (state == dmbc_pkg::DMBC_REF) begin
      refresh_pending <= 1'b0;
    end
  end

  // Array timing sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state                   <= dmbc_pkg::DMBC_IDLE;
      seq_cnt                 <= 4'h0;
      is_write                <= 1'b0;
      portion_done            <= 1'b0;
      refresh_done            <= 1'b0;
      muxed_chip_address      <= 7'h00;
      row_strobe_low_array_n  <= 1'b1;
      row_strobe_high_array_n <= 1'b1;
      col_strobe_a_n          <= 1'b1;
      col_strobe_b_n          <= 1'b1;
      byte_write_low_n        <= 1'b1;
      byte_write_high_n       <= 1'b1;
      mem_wdata               <= 16'h0000;
      par_wdata               <= 2'h0;
      rd_data_q               <= 16'h0000;
      parity_fault_latched    <= 1'b0;
    end else begin
      portion_done <= 1'b0;
      refresh_done <= 1'b0;
      seq_cnt      <= seq_cnt + 4'h1;
      case (state)
        dmbc_pkg::DMBC_IDLE: begin
          seq_cnt <= 4'h0;
          if (read_request || write_request) begin
            state <= dmbc_pkg::DMBC_ARB;
          end else if (refresh_pending) begin
            state                   <= dmbc_pkg::DMBC_REF;
            muxed_chip_address      <= refresh_row;
            row_strobe_low_array_n  <= 1'b0;
            row_strobe_high_array_n <= 1'b0;
          end
        end
        dmbc_pkg::DMBC_ARB: begin
          if (seq_cnt == 4'(`DMBC_ARB_HOLD_CYC - 1)) begin
            seq_cnt <= 4'h0;
            if (refresh_pending) begin
              state                   <= dmbc_pkg::DMBC_REF;
              muxed_chip_address      <= refresh_row;
              row_strobe_low_array_n  <= 1'b0;
              row_strobe_high_array_n <= 1'b0;
            end else begin
              state <= dmbc_pkg::DMBC_ROW;
            end
          end
        end
        dmbc_pkg::DMBC_REF: begin
          if (seq_cnt == 4'(`DMBC_REFRESH_LEN_CYC - `DMBC_PRECHG_CYC - 1)) begin
            row_strobe_low_array_n  <= 1'b1;
            row_strobe_high_array_n <= 1'b1;
          end
          if (seq_cnt == 4'(`DMBC_REFRESH_LEN_CYC - 1)) begin
            seq_cnt      <= 4'h0;
            refresh_done <= 1'b1;
            // Access that waited behind refresh starts at once
            state <= (read_request || write_request) ? dmbc_pkg::DMBC_ROW
                                                     : dmbc_pkg::DMBC_IDLE;
          end
        end
        dmbc_pkg::DMBC_ROW: begin
          if (seq_cnt == 4'h0) begin
            is_write                <= write_request;
            muxed_chip_address      <= row_q;
            row_strobe_low_array_n  <= hit_q_high;
            row_strobe_high_array_n <= ~hit_q_high;
            mem_wdata               <= bus_dal_in[15:0];
            par_wdata[0] <= (^bus_dal_in[7:0]) ^ bus_dal_in[16];
            par_wdata[1] <= (^bus_dal_in[15:8]) ^ bus_dal_in[16];
          end
          if (seq_cnt == 4'(`DMBC_ROW_CYC - 1)) begin
            seq_cnt            <= 4'h0;
            state              <= dmbc_pkg::DMBC_COL;
            muxed_chip_address <= col_q;
            col_strobe_a_n     <= hit_q_high;
            col_strobe_b_n     <= ~hit_q_high;
            if (is_write) begin
              // Same sequence for byte and word; only strobes differ
              byte_write_low_n  <= bus_wtbt & a0_q;
              byte_write_high_n <= bus_wtbt & ~a0_q;
            end
          end
        end
        dmbc_pkg::DMBC_COL: begin
          if (seq_cnt == 4'(`DMBC_COL_CYC - 1)) begin
            seq_cnt                 <= 4'h0;
            state                   <= dmbc_pkg::DMBC_PRE;
            portion_done            <= 1'b1;
            row_strobe_low_array_n  <= 1'b1;
            row_strobe_high_array_n <= 1'b1;
            col_strobe_a_n          <= 1'b1;
            col_strobe_b_n          <= 1'b1;
            byte_write_low_n        <= 1'b1;
            byte_write_high_n       <= 1'b1;
            if (!is_write) begin
              rd_data_q            <= mem_rdata;
              parity_fault_latched <= fault_now;
            end
          end
        end
        dmbc_pkg::DMBC_PRE: begin
          if (seq_cnt == 4'(`DMBC_PRECHG_CYC - 1)) begin
            seq_cnt <= 4'h0;
            state   <= dmbc_pkg::DMBC_IDLE;
          end
        end
        default: begin
          state <= dmbc_pkg::DMBC_IDLE;
        end
      endcase
    end
  end

  // Reply and read data toward the processor bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reply_cnt    <= 4'h0;
      bus_reply    <= 1'b0;
      bus_dal_out  <= 18'h00000;
      bus_dal_oe_n <= 1'b1;
    end else begin
      if (portion_done) begin
        reply_cnt <= cfg[`DMBC_CFG_PARITY_BIT] ? 4'(PAR_DELAY_CYC) : 4'h0;
      end else if (reply_cnt != 4'h0) begin
        reply_cnt <= reply_cnt - 4'h1;
      end
      bus_reply <= !portion_done && reply_cnt == 4'h0
                 && ((read_flag && read_done && !write_done && bus_din)
                     || (write_done && bus_dout));
      bus_dal_oe_n <= ~(!portion_done && reply_cnt == 4'h0 && read_flag && read_done
                        && !write_done && bus_din);
      bus_dal_out  <= {1'b0, parity_fault_latched, rd_data_q};
    end
  end
endmodule

// ===== hdl/dmbc_regs.svh
// Overview of operation
// - Byte write strobes only addressed byte
// - Chip address multiplexed as row then column
// - Range decode picks low or high row strobe
// - Board hit only inside configured address range
// - Outside refresh line inhibits address decode
// - Top bank blocked, optionally only upper half
// - Sync edge sets read or write flag
// - Write request waits for data-out strobe
// - Any request starts sequence under cycle lock
// - Running refresh finishes before access starts
// - Access held for arbitration, refresh may win
// - Refresh allowed once lock drops
// - Read-modify-write is read then write
// - Same timing for byte and word writes
// - Reply driven for every accepted access
// - Refresh timer period fourteen and a half microseconds
// - Row counter advances once per refresh
// - One parity bit generated per byte
// - Read checks parity, error on line 16
// - Reply delayed for parity on parity boards
// - Line 16 during write stores bad parity
// - Five switches select starting bank number
`ifndef DMBC_REGS_SVH
`define DMBC_REGS_SVH

`define DMBC_CLK_NS              50
`define DMBC_REFRESH_PERIOD_NS   14500
`define DMBC_REFRESH_PERIOD_CYC  (`DMBC_REFRESH_PERIOD_NS / `DMBC_CLK_NS)
`define DMBC_ARB_HOLD_NS         100
`define DMBC_ARB_HOLD_CYC        ((`DMBC_ARB_HOLD_NS + `DMBC_CLK_NS - 1) / `DMBC_CLK_NS)
`define DMBC_REFRESH_LEN_NS      575
`define DMBC_REFRESH_LEN_CYC     ((`DMBC_REFRESH_LEN_NS + `DMBC_CLK_NS - 1) / `DMBC_CLK_NS)
`define DMBC_ROW_CYC             2
`define DMBC_COL_CYC             3
`define DMBC_PRECHG_CYC          3
`define DMBC_PAR_DELAY_CYC       2

`define DMBC_CFG_OFFSET          4'h0
`define DMBC_STATUS_OFFSET       4'h4
`define DMBC_CFG_RESET           9'h000
`define DMBC_CFG_START_LSB       0
`define DMBC_CFG_BANK7_BIT       5
`define DMBC_CFG_CHIP16K_BIT     6
`define DMBC_CFG_CHIP32_BIT      7
`define DMBC_CFG_PARITY_BIT      8
`define DMBC_ST_FAULT_BIT        0
`define DMBC_ST_STICKY_BIT       1
`define DMBC_ST_LOCK_BIT         2
`define DMBC_ST_REFPEND_BIT      3
`define DMBC_ST_ROW_LSB          8

`endif

// ===== hdl/dmbc_pkg.sv
package dmbc_pkg;
  typedef enum logic [2:0] {
    DMBC_IDLE,
    DMBC_ARB,
    DMBC_ROW,
    DMBC_COL,
    DMBC_PRE,
    DMBC_REF
  } dmbc_state_t;
  typedef enum logic [1:0] {
    DMBC_RESP_OKAY   = 2'h0,
    DMBC_RESP_SLVERR = 2'h2
  } dmbc_resp_t;
endpackage

// ===== hdl/dmbc_range_decode.sv
`timescale 1ns/100ps
module dmbc_range_decode (
  input  wire logic [17:0] bus_addr,
  input  wire logic [4:0]  start_address_switches,
  input  wire logic        bank7_lower_en,
  input  wire logic        chips16k,
  input  wire logic        chips32,
  input  wire logic        bus_bank7,
  input  wire logic        outside_refresh_seen,
  output logic             board_hit,
  output logic             high_range,
  output logic [6:0]       row_addr,
  output logic [6:0]       col_addr
);
  logic [4:0]  rel_bank;
  logic [3:0]  nbanks;
  logic [14:0] rel_word;
  logic        in_range;
  logic        block7;

  always_comb begin
    rel_bank = 5'(bus_addr[17:13] - start_address_switches);
    nbanks   = 4'h1 << {chips16k, chips32};
    in_range = ({1'b0, rel_bank} < {2'h0, nbanks});
    block7   = bus_bank7 & (~bank7_lower_en | bus_addr[12]);
    board_hit = in_range & ~block7 & ~outside_refresh_seen;
    rel_word = {rel_bank[2:0], bus_addr[12:1]};
    high_range = chips32 & (chips16k ? rel_word[14] : rel_word[12]);
    if (chips16k) begin
      row_addr = rel_word[6:0];
      col_addr = rel_word[13:7];
    end else begin
      row_addr = {1'b0, rel_word[5:0]};
      col_addr = {1'b0, rel_word[11:6]};
    end
  end
endmodule

// ===== hdl/dmbc_refresh_timer.sv
`timescale 1ns/100ps
`include "dmbc_regs.svh"
module dmbc_refresh_timer #(
  parameter int PERIOD_CYC = `DMBC_REFRESH_PERIOD_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       chips16k,
  input  wire logic       refresh_done,
  output logic            refresh_tick,
  output logic [6:0]      refresh_row
);
  logic [15:0] period_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_cnt   <= 16'h0000;
      refresh_tick <= 1'b0;
    end else if (period_cnt == 16'(PERIOD_CYC - 1)) begin
      period_cnt   <= 16'h0000;
      refresh_tick <= 1'b1;
    end else begin
      period_cnt   <= period_cnt + 16'h0001;
      refresh_tick <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_row <= 7'h00;
    end else if (refresh_done) begin
      if (refresh_row == (chips16k ? 7'h7F : 7'h3F)) begin
        refresh_row <= 7'h00;
      end else begin
        refresh_row <= refresh_row + 7'h01;
      end
    end
  end
endmodule

// ===== tb/dmbc_monitor.sv
`timescale 1ns/100ps
module dmbc_monitor #(
  parameter int REFRESH_PERIOD_CYC = 290
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        bus_sync,
  input wire logic        bus_din,
  input wire logic        bus_dout,
  input wire logic [17:0] bus_dal_in,
  input wire logic        bus_bank7,
  input wire logic        outside_refresh_seen,
  input wire logic        bus_reply,
  input wire logic        bus_dal_oe_n,
  input wire logic        row_strobe_low_array_n,
  input wire logic        row_strobe_high_array_n,
  input wire logic        col_strobe_a_n,
  input wire logic        col_strobe_b_n,
  input wire logic        byte_write_low_n,
  input wire logic        byte_write_high_n
);
  int unsigned gap;
  always_ff @(posedge aclk) begin
    if (!aresetn || (!row_strobe_low_array_n && !row_strobe_high_array_n)) begin
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_quiet;
    (!bus_din && !bus_dout) ##1 (!bus_din && !bus_dout);
  endsequence
  sequence s_lane_write;
    !byte_write_low_n || !byte_write_high_n;
  endsequence
  a_reply_drops: assert property (s_quiet |-> !bus_reply)
    else $error("reply stands after strobes fell");
  a_refresh_gap: assert property (gap < REFRESH_PERIOD_CYC + 30)
    else $error("refresh period too long");
  a_row_then_col: assert property ($fell(col_strobe_a_n) |->
    !row_strobe_low_array_n && !$past(row_strobe_low_array_n))
    else $error("column strobe without leading row strobe");
  a_refresh_ras_only: assert property ((!row_strobe_low_array_n &&
    !row_strobe_high_array_n) |-> col_strobe_a_n && col_strobe_b_n)
    else $error("column strobe during refresh");
  a_lane_in_column: assert property (s_lane_write |->
    !col_strobe_a_n || !col_strobe_b_n)
    else $error("byte strobe outside column phase");
  a_write_after_dout: assert property (s_lane_write |-> bus_dout && bus_sync)
    else $error("array write without data strobe");
  a_drive_with_reply: assert property (!bus_dal_oe_n |-> bus_reply && !bus_dout)
    else $error("bus driven outside read reply");
  a_refresh_inhibit: assert property (($rose(bus_sync) && outside_refresh_seen)
    |=> !bus_reply [*8])
    else $error("reply to bus refresh");
  a_top_bank_block: assert property (($rose(bus_sync) && bus_bank7 &&
    bus_dal_in[12]) |=> !bus_reply [*8])
    else $error("reply in blocked top bank");
endmodule
bind dmbc_top dmbc_monitor #(.REFRESH_PERIOD_CYC(REFRESH_PERIOD_CYC)) u_mon (
  .aclk, .aresetn, .bus_sync, .bus_din, .bus_dout, .bus_dal_in, .bus_bank7,
  .outside_refresh_seen, .bus_reply, .bus_dal_oe_n, .row_strobe_low_array_n,
  .row_strobe_high_array_n, .col_strobe_a_n, .col_strobe_b_n, .byte_write_low_n,
  .byte_write_high_n);

// ===== tb/dmbc_dram_model.sv
`timescale 1ns/100ps
module dmbc_dram_model (
  input  wire logic        aclk,
  input  wire logic [6:0]  muxed_chip_address,
  input  wire logic        row_strobe_low_array_n,
  input  wire logic        row_strobe_high_array_n,
  input  wire logic        col_strobe_a_n,
  input  wire logic        col_strobe_b_n,
  input  wire logic        byte_write_low_n,
  input  wire logic        byte_write_high_n,
  input  wire logic [15:0] mem_wdata,
  input  wire logic [1:0]  par_wdata,
  output logic      [15:0] mem_rdata,
  output logic      [1:0]  par_rdata
);
  logic [17:0] cells [int];
  logic [17:0] cur;
  logic [7:0]  row_q = 8'h00;
  int          key;
  wire         ras_n = row_strobe_low_array_n & row_strobe_high_array_n;
  wire         cas_n = col_strobe_a_n & col_strobe_b_n;
  initial mem_rdata = 16'h0000;
  initial par_rdata = 2'h0;
  // Data lines toggle whenever no column is selected
  always @(posedge aclk) begin
    key = int'({row_q, muxed_chip_address});
    cur = cells.exists(key) ? cells[key] : 18'h00000;
    if (!ras_n && cas_n) row_q <= {~row_strobe_high_array_n, muxed_chip_address};
    if (!ras_n && !cas_n) begin
      if (!byte_write_low_n) cur = {cur[17], par_wdata[0], cur[15:8], mem_wdata[7:0]};
      if (!byte_write_high_n) cur = {par_wdata[1], cur[16], mem_wdata[15:8], cur[7:0]};
      cells[key] = cur;
      mem_rdata <= cur[15:0];
      par_rdata <= cur[17:16];
    end else begin
      mem_rdata <= ~mem_rdata;
      par_rdata <= ~par_rdata;
    end
  end
endmodule

// ===== tb/dmbc_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module dmbc_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic bus_sync = 1'b0, bus_din = 1'b0, bus_dout = 1'b0, bus_wtbt = 1'b0;
  logic bus_bank7 = 1'b0, outside_refresh_seen = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0, d32;
  logic [17:0] bus_dal_in = 18'h0, q;
  logic [1:0] r2;
  wire awready, wready, bvalid, arready, rvalid, bus_reply, bus_dal_oe_n;
  wire row_strobe_low_array_n, row_strobe_high_array_n, col_strobe_a_n, col_strobe_b_n;
  wire byte_write_low_n, byte_write_high_n;
  wire [1:0] bresp, rresp, par_wdata, par_rdata;
  wire [31:0] rdata;
  wire [17:0] bus_dal_out;
  wire [15:0] mem_wdata, mem_rdata;
  wire [6:0] muxed_chip_address;
  int err_count = 0;
  int checked = 0;
  dmbc_top #(.REFRESH_PERIOD_CYC(40)) u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .bus_dal_in, .bus_sync, .bus_din, .bus_dout, .bus_wtbt,
    .bus_bank7, .outside_refresh_seen, .bus_reply, .bus_dal_out, .bus_dal_oe_n,
    .muxed_chip_address, .row_strobe_low_array_n, .row_strobe_high_array_n, .col_strobe_a_n,
    .col_strobe_b_n, .byte_write_low_n, .byte_write_high_n, .mem_wdata, .mem_rdata,
    .par_wdata, .par_rdata);
  dmbc_dram_model u_mem (.aclk, .muxed_chip_address, .row_strobe_low_array_n,
    .row_strobe_high_array_n, .col_strobe_a_n, .col_strobe_b_n, .byte_write_low_n,
    .byte_write_high_n, .mem_wdata, .par_wdata, .mem_rdata, .par_rdata);
  initial forever #25 aclk = ~aclk;
  task automatic end_of_test();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail_wait();
    err_count++;
    $display("MISMATCH handshake expected answer seen none");
    end_of_test();
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) fail_wait();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) fail_wait();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic wait_reply(input logic lvl);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (bus_reply === lvl) break;
    end
    if (i == 200) fail_wait();
  endtask
  // Read portion, write portion, or both under one address phase
  task automatic bus_op(input logic [17:0] a, input logic rd, input logic wr, input logic bw,
                        input logic [17:0] d, output logic [17:0] o);
    @(posedge aclk);
    bus_dal_in <= a;
    bus_wtbt <= wr & ~rd;
    bus_sync <= 1'b1;
    if (rd) begin
      @(posedge aclk);
      bus_din <= 1'b1;
      wait_reply(1'b1);
      o = bus_dal_out;
      bus_din <= 1'b0;
      wait_reply(1'b0);
    end
    if (wr) begin
      repeat (10) @(posedge aclk);
      `CHK("reply before data strobe", 1'b0, bus_reply)
      bus_dal_in <= d;
      bus_wtbt <= bw;
      bus_dout <= 1'b1;
      wait_reply(1'b1);
      bus_dout <= 1'b0;
      wait_reply(1'b0);
    end
    bus_sync <= 1'b0;
  endtask
  task automatic no_hit(input logic [17:0] a, input logic rf, input logic b7);
    @(posedge aclk);
    bus_dal_in <= a;
    outside_refresh_seen <= rf;
    bus_bank7 <= b7;
    bus_sync <= 1'b1;
    @(posedge aclk);
    bus_din <= 1'b1;
    repeat (20) begin
      @(posedge aclk);
      `CHK("reply outside range", 1'b0, bus_reply)
    end
    bus_din <= 1'b0;
    bus_sync <= 1'b0;
    outside_refresh_seen <= 1'b0;
    bus_bank7 <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_wr(4'h0, 32'h1E2, r2);
    `CHK("cfg bresp", 2'h0, r2)
    axi_rd(4'h0, d32, r2);
    `CHK("cfg value", 32'h1E2, d32)
    axi_wr(4'hC, 32'h1, r2);
    `CHK("unmapped bresp", 2'h2, r2)
    axi_rd(4'hC, d32, r2);
    `CHK("unmapped rdata", 34'h200000000, {r2, d32})
    bus_op(18'h06010, 1'b0, 1'b1, 1'b0, 18'h0A5C3, q);
    bus_op(18'h06010, 1'b1, 1'b0, 1'b0, 18'h0, q);
    `CHK("word read", 17'h0A5C3, q[16:0])
    bus_op(18'h06011, 1'b0, 1'b1, 1'b1, 18'h07E00, q);
    bus_bank7 <= 1'b1;
    bus_op(18'h06010, 1'b1, 1'b0, 1'b0, 18'h0, q);
    bus_bank7 <= 1'b0;
    `CHK("byte merge", 17'h07EC3, q[16:0])
    bus_op(18'h06010, 1'b1, 1'b1, 1'b0, 18'h11234, q);
    `CHK("modify read", 16'h7EC3, q[15:0])
    bus_op(18'h06010, 1'b1, 1'b0, 1'b0, 18'h0, q);
    `CHK("forced parity", 17'h11234, q[16:0])
    axi_rd(4'h4, d32, r2);
    `CHK("fault status", 2'h3, d32[1:0])
    bus_op(18'h0FFFE, 1'b0, 1'b1, 1'b0, 18'h00F0F, q);
    bus_op(18'h07FFE, 1'b0, 1'b1, 1'b0, 18'h0AAAA, q);
    for (int k = 0; k < 6; k++) begin
      bus_op(18'h0FFFE, 1'b1, 1'b0, 1'b0, 18'h0, q);
      `CHK("repeat read", 17'h00F0F, q[16:0])
    end
    no_hit(18'h14000, 1'b0, 1'b0);
    no_hit(18'h02000, 1'b0, 1'b0);
    no_hit(18'h06010, 1'b1, 1'b0);
    no_hit(18'h07010, 1'b0, 1'b1);
    repeat (120) @(posedge aclk);
    end_of_test();
  end
endmodule
